// ### nbg_noise_byte_generator.sv
// What this block does
// [R1] Collect random bits only after power-on bit is written one; idle otherwise.
// [R2] Shift corrected bits into eight-bit holder; completed byte shown in data register.
// [R3] Valid flag sets on fresh byte, clears on data read, sets again later.
// [R4] New-byte interrupt follows the valid flag exactly.
// [R5] Power-on rising edge clears data register and valid flag.
// [R6] Software ignores data and flag while powered down.
// [R7] Bias-fix bit selects corrector; cleared bypasses it for faster bits.
// [R8] Byte time is variable, about 0.1ms bypassed, four times corrected.
// [R9] First byte after power-on waits extra start-up time of 0.25ms.
// [R10] Control: power bit7, bias bit6 RW, valid bit5 RO, reset 0x40.
// [R11] Data register at 0xD7, eight bits, read-only, resets to zero.
// [R12] Generation continues while the processor is in standby.
// [R13] Noise is an input bit with strobe; corrector is a pair extractor.
// [R14] Clearing power-on stops collection and drops the partial byte.
module nbg_noise_byte_generator
	import nbg_pkg::*;
#(
	parameter int STARTUP_CYC = NBG_STARTUP_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Special-function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	// Processor standby indication, does not stop the generator
	input wire logic standby_i,
	// Noise source
	input wire logic noise_bit_i,
	input wire logic noise_valid_i,
	// Interrupt
	output logic new_byte_irq_o
);
	import nbg_pkg::*;

	// A start-up span of zero is refused, and the warm-up counter cannot hold one wider than itself
	if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << NBG_CNT_W)) begin : g_bad_startup
		$error("STARTUP_CYC out of range");
	end

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_ff;
	logic rst_sync_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire rst_n = rst_sync_ff;

	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	logic gen_power_on_ff;
	logic bias_fix_enable_ff;
	logic byte_valid_flag_ff;
	logic [7:0] byte_out_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [NBG_CNT_W-1:0] warm_cnt_ff;
	logic [7:0] rdata_ff;
	logic irq_ff;

	wire ctrl_wr = sfr_wr_i && (sfr_addr_i == NBG_ADDR_CTRL);
	wire data_rd = sfr_rd_i && (sfr_addr_i == NBG_ADDR_DATA);
	wire ctrl_rd = sfr_rd_i && (sfr_addr_i == NBG_ADDR_CTRL);
	wire nxt_power = ctrl_wr ? sfr_wdata_i[NBG_BIT_POWER] : gen_power_on_ff;
	wire nxt_bias = ctrl_wr ? sfr_wdata_i[NBG_BIT_BIASFIX] : bias_fix_enable_ff;
	wire power_rise = nxt_power && !gen_power_on_ff; // [R5]
	// Standby is deliberately not part of this term
	wire running = gen_power_on_ff && (warm_cnt_ff == '0); // [R1] [R9] [R12]
	wire [7:0] ctrl_view = {gen_power_on_ff, bias_fix_enable_ff, byte_valid_flag_ff, 5'h00};

	// ----------------------------------------
	// Corrector
	// ----------------------------------------
	logic fix_bit;
	logic fix_valid;
	nbg_bias_fix u_fix (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.run_i(running),
		.enable_i(bias_fix_enable_ff),
		.raw_bit_i(noise_bit_i),
		.raw_valid_i(noise_valid_i && running), // [R13]
		.bit_o(fix_bit),
		.valid_o(fix_valid)
	);

	// Pipeline hides corrector output that arrives right after power-off
	// Byte time follows the source strobe rate; the corrector drops pairs and slows it
	wire take_bit = fix_valid && running; // [R8]
	wire byte_done = take_bit && (bit_cnt_ff == 3'(NBG_BITS - 1));
	wire [7:0] shifted = {shift_ff[6:0], fix_bit}; // [R2]

	wire nxt_valid = power_rise ? 1'b0 :
		byte_done ? 1'b1 : // [R3]
		data_rd ? 1'b0 : byte_valid_flag_ff;
	wire [7:0] nxt_byte = power_rise ? NBG_DATA_RESET : byte_done ? shifted : byte_out_ff;
	wire [2:0] nxt_cnt = (!gen_power_on_ff || power_rise) ? 3'h0 : // [R14]
		take_bit ? bit_cnt_ff + 3'h1 : bit_cnt_ff;
	wire [NBG_CNT_W-1:0] nxt_warm = power_rise ? NBG_CNT_W'(STARTUP_CYC) : // [R9]
		(warm_cnt_ff != '0) ? warm_cnt_ff - NBG_CNT_W'(1) : warm_cnt_ff;
	// Read data is registered; value reflects state before this access
	wire [7:0] nxt_rdata = ctrl_rd ? ctrl_view : data_rd ? byte_out_ff : 8'h00;

	// ----------------------------------------
	// State
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			gen_power_on_ff <= NBG_CTRL_RESET[NBG_BIT_POWER]; // [R10]
			bias_fix_enable_ff <= NBG_CTRL_RESET[NBG_BIT_BIASFIX];
			byte_valid_flag_ff <= NBG_CTRL_RESET[NBG_BIT_VALID];
		end else begin
			gen_power_on_ff <= nxt_power; // [R1]
			bias_fix_enable_ff <= nxt_bias; // [R7]
			byte_valid_flag_ff <= nxt_valid; // [R3] [R5]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			byte_out_ff <= NBG_DATA_RESET; // [R11]
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
			warm_cnt_ff <= '0;
		end else begin
			byte_out_ff <= nxt_byte; // [R2] [R5]
			shift_ff <= take_bit ? shifted : shift_ff;
			bit_cnt_ff <= nxt_cnt;
			warm_cnt_ff <= nxt_warm;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_valid; // [R4]
		end
	end

	assign sfr_rdata_o = rdata_ff;
	assign new_byte_irq_o = irq_ff;
endmodule : nbg_noise_byte_generator

// ### nbg_pkg.sv
package nbg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] NBG_ADDR_CTRL = 8'hD6;
	localparam logic [7:0] NBG_ADDR_DATA = 8'hD7;
	localparam int NBG_BIT_POWER = 7;
	localparam int NBG_BIT_BIASFIX = 6;
	localparam int NBG_BIT_VALID = 5;
	localparam logic [7:0] NBG_CTRL_RESET = 8'h40;
	localparam logic [7:0] NBG_DATA_RESET = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int NBG_CLK_HZ = 40000000;
	localparam int NBG_STARTUP_NS = 250000;
	localparam int NBG_STARTUP_CYC = (NBG_STARTUP_NS * (NBG_CLK_HZ / 1000000) + 999) / 1000;
	localparam int NBG_BYTE_NS = 100000;
	localparam int NBG_BYTE_CYC = NBG_BYTE_NS * (NBG_CLK_HZ / 1000000) / 1000;
	localparam int NBG_BITS = 8;
	localparam int NBG_CNT_W = 16;
	// ----------------------------------------
	// Corrector pair states
	// ----------------------------------------
	typedef enum logic [1:0] {
		NBG_PAIR_FIRST = 2'b01,
		NBG_PAIR_SECOND = 2'b10
	} nbg_pair_e;
endpackage : nbg_pkg

// ### nbg_bias_fix.sv
module nbg_bias_fix
	import nbg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic enable_i,
	// Raw stream
	input wire logic raw_bit_i,
	input wire logic raw_valid_i,
	// Corrected stream
	output logic bit_o,
	output logic valid_o
);
	import nbg_pkg::*;

	nbg_pair_e pair_ff;
	nbg_pair_e nxt_pair;
	logic first_ff;
	logic nxt_first;
	logic bit_ff;
	logic valid_ff;
	logic nxt_bit;
	logic nxt_valid;

	// Von Neumann: 01 gives 0, 10 gives 1, equal pairs are dropped
	wire take_second = raw_valid_i && (pair_ff == NBG_PAIR_SECOND);
	wire pair_differs = take_second && (first_ff != raw_bit_i);

	always_comb begin
		nxt_pair = pair_ff;
		nxt_first = first_ff;
		nxt_bit = bit_ff;
		nxt_valid = 1'b0;
		if (!run_i) begin
			nxt_pair = NBG_PAIR_FIRST; // [R14]
		end else if (!enable_i) begin
			nxt_pair = NBG_PAIR_FIRST;
			nxt_bit = raw_bit_i; // [R7]
			nxt_valid = raw_valid_i;
		end else if (raw_valid_i) begin
			unique case (pair_ff)
				NBG_PAIR_FIRST: begin
					nxt_first = raw_bit_i;
					nxt_pair = NBG_PAIR_SECOND;
				end
				NBG_PAIR_SECOND: begin
					nxt_pair = NBG_PAIR_FIRST;
					nxt_bit = first_ff; // [R13]
					nxt_valid = pair_differs; // [R7]
				end
				default: nxt_pair = NBG_PAIR_FIRST;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pair_ff <= NBG_PAIR_FIRST;
			first_ff <= 1'b0;
			bit_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			pair_ff <= nxt_pair;
			first_ff <= nxt_first;
			bit_ff <= nxt_bit;
			valid_ff <= nxt_valid;
		end
	end

	assign bit_o = bit_ff;
	assign valid_o = valid_ff;
endmodule : nbg_bias_fix

// ### nbg_sva.sv
module nbg_sva
	import nbg_pkg::*;
#(
	parameter int STARTUP_CYC = NBG_STARTUP_CYC
) (
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic standby_i,
	input wire logic noise_bit_i,
	input wire logic noise_valid_i,
	input wire logic new_byte_irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Shadow of the control bits
	// ----------------------------------------
	logic [1:0] ctl_ff;
	logic [15:0] cnt_ff;
	logic wr_ctl;
	logic on_rise;
	logic rd_dat;
	assign wr_ctl = sfr_wr_i && sfr_addr_i == NBG_ADDR_CTRL;
	assign on_rise = wr_ctl && sfr_wdata_i[7] && !ctl_ff[1];
	assign rd_dat = sfr_rd_i && sfr_addr_i == NBG_ADDR_DATA;
	// Saturates so a long idle run never wraps back into the warm-up window
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_ff <= 2'h1;
			cnt_ff <= 16'hFFFF;
		end else begin
			if (wr_ctl) ctl_ff <= sfr_wdata_i[7:6];
			if (on_rise) cnt_ff <= 16'h0000;
			else if (cnt_ff != 16'hFFFF) cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd_idle;
		!sfr_rd_i |=> sfr_rdata_o == 8'h00;
	endproperty
	property p_rd_ctl;
		sfr_rd_i && sfr_addr_i == NBG_ADDR_CTRL && !sfr_wr_i
			|=> sfr_rdata_o[7:6] == $past(ctl_ff) && sfr_rdata_o[4:0] == 5'h00;
	endproperty
	property p_rd_clr;
		rd_dat && !$past(noise_valid_i) && !noise_valid_i ##1 !noise_valid_i [*3]
			|-> ##1 !new_byte_irq_o;
	endproperty
	property p_on_clr;
		on_rise |=> !new_byte_irq_o [*3];
	endproperty
	property p_on_dat;
		on_rise ##[2:8] rd_dat |=> sfr_rdata_o == 8'h00;
	endproperty
	property p_warm;
		$rose(new_byte_irq_o) |-> cnt_ff >= STARTUP_CYC + NBG_BITS + 1;
	endproperty
	property p_off;
		$rose(new_byte_irq_o) |-> $past(ctl_ff[1], 2);
	endproperty
	property p_irq_fall;
		$fell(new_byte_irq_o) |-> $past(rd_dat || on_rise);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
	a_rd_clr: assert property (p_rd_clr) else $error("irq kept after read");
	a_on_clr: assert property (p_on_clr) else $error("irq kept after power on");
	a_on_dat: assert property (p_on_dat) else $error("data kept after power on");
	a_warm: assert property (p_warm) else $error("byte during warm-up");
	a_off: assert property (p_off) else $error("byte while powered down");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
	c_byte: cover property ($rose(new_byte_irq_o));
	c_on: cover property (on_rise);
	c_rd: cover property (rd_dat && new_byte_irq_o);
endmodule : nbg_sva

// ### nbg_noise_byte_generator_test.sv
module nbg_noise_byte_generator_test;
	timeunit 1ns;
	timeprecision 100ps;
	import nbg_pkg::*;
	localparam int SC = 40;
	logic clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, new_byte_irq_o;
	logic standby_i = 1'b0, noise_bit_i = 1'b0, noise_valid_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d, b;
	logic [31:0] seed = 32'h29E8646A;
	int mismatches = 0, n_tests = 0;
	nbg_noise_byte_generator #(.STARTUP_CYC(SC)) DUT (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
		.sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .standby_i, .noise_bit_i, .noise_valid_i,
		.new_byte_irq_o);
	// ----------------------------------------
	// Clock, random source and helpers
	// ----------------------------------------
	always #12.5 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	always @(posedge clk_i) begin
		seed <= lfsr(seed);
		standby_i <= seed[5];
	end
	task automatic test_done;
		if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= v;
		sfr_wr_i <= w;
		sfr_rd_i <= !w;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
		sfr_rd_i <= 1'b0;
		#1 d = sfr_rdata_o;
	endtask : acc
	task automatic nb(input logic v);
		@(posedge clk_i);
		noise_bit_i <= v;
		noise_valid_i <= 1'b1;
		@(posedge clk_i);
		noise_valid_i <= 1'b0;
	endtask : nb
	// Junk equal pairs are dropped by the corrector, so only first bits of 01/10 land
	task automatic feed(input logic [7:0] v, input logic fix, input int n);
		logic j;
		for (int i = 7; i > 7 - n; i--) begin
			j = seed[1];
			if (fix && seed[0]) begin
				nb(j);
				nb(j);
			end
			nb(v[i]);
			if (fix) nb(!v[i]);
		end
	endtask : feed
	task automatic pon(input logic [7:0] v);
		acc(1'b1, NBG_ADDR_CTRL, v);
		acc(1'b0, NBG_ADDR_DATA, 8'h00);
		chk(d, 8'h00);
		acc(1'b0, NBG_ADDR_CTRL, 8'h00);
		chk(d, v);
		repeat (SC + 4) @(posedge clk_i);
	endtask : pon
	task automatic getb(input logic [7:0] e);
		repeat (6) @(posedge clk_i);
		#1 chk({7'h00, new_byte_irq_o}, 8'h01);
		acc(1'b0, NBG_ADDR_CTRL, 8'h00);
		chk(d & 8'h20, 8'h20);
		acc(1'b0, NBG_ADDR_DATA, 8'h00);
		chk(d, e);
		repeat (5) @(posedge clk_i);
		#1 chk({7'h00, new_byte_irq_o}, 8'h00);
	endtask : getb
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		acc(1'b0, NBG_ADDR_CTRL, 8'h00);
		chk(d, NBG_CTRL_RESET);
		acc(1'b1, NBG_ADDR_DATA, 8'hFF);
		acc(1'b1, NBG_ADDR_CTRL, 8'h3F);
		acc(1'b0, NBG_ADDR_DATA, 8'h00);
		chk(d, NBG_DATA_RESET);
		acc(1'b0, NBG_ADDR_CTRL, 8'h00);
		chk(d, 8'h00);
		feed(8'hA5, 1'b0, 8);
		repeat (6) @(posedge clk_i);
		#1 chk({7'h00, new_byte_irq_o}, 8'h00);
		for (int k = 0; k < 2; k++) begin
			b = seed[7:0];
			pon(k[0] ? 8'hC0 : 8'h80);
			feed(b, k[0], 8);
			getb(b);
			acc(1'b1, NBG_ADDR_CTRL, 8'h00);
		end
		pon(8'h80);
		b = seed[7:0];
		feed(b, 1'b0, 8);
		feed(~b, 1'b0, 4);
		#1 chk({7'h00, new_byte_irq_o}, 8'h01);
		acc(1'b1, NBG_ADDR_CTRL, 8'h00);
		pon(8'h80);
		b = seed[7:0];
		feed(b, 1'b0, 8);
		getb(b);
		test_done();
	end
	initial begin
		repeat (8000) @(posedge clk_i);
		mismatches++;
		test_done();
	end
endmodule : nbg_noise_byte_generator_test
bind nbg_noise_byte_generator nbg_sva #(.STARTUP_CYC(STARTUP_CYC)) u_sva (.clk_i, .rst_n_i,
	.sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .standby_i, .noise_bit_i,
	.noise_valid_i, .new_byte_irq_o);
